// ---- hdl/timer_cmp_map.vh ----
// register offsets, field positions, reset values and timing for the compare timer
`ifndef TIMER_CMP_MAP_VH
`define TIMER_CMP_MAP_VH

`define OFS_CTRL_ONE 12'h000
`define OFS_CTRL_TWO 12'h004
`define OFS_STATUS 12'h008
`define OFS_CMP1_HI 12'h00C
`define OFS_CMP1_LO 12'h010
`define OFS_CMP2_HI 12'h014
`define OFS_CMP2_LO 12'h018
`define OFS_CAP1_HI 12'h01C
`define OFS_CAP1_LO 12'h020
`define OFS_CAP2_HI 12'h024
`define OFS_CAP2_LO 12'h028
`define OFS_COUNT_HI 12'h02C
`define OFS_COUNT_LO 12'h030

// timer_control_one fields
`define C1_LEVEL_AFTER 0
`define C1_TRIG_EDGE 1
`define C1_LEVEL_DURING 2
`define C1_FORCE1 3
`define C1_FORCE2 4
`define C1_CMP_IRQ_EN 6
`define C1_CAP_IRQ_EN 7

// timer_control_two fields
`define C2_PIN_EN1 0
`define C2_PIN_EN2 1
`define C2_SINGLE_PULSE 2
`define C2_PWM 3
`define C2_TICK_LO 4
`define C2_TICK_HI 5
`define C2_CAP2_EDGE 6
`define C2_EXT_EDGE 7

// timer_status_reg fields
`define ST_CMP1 0
`define ST_CMP2 1
`define ST_CAP1 2
`define ST_CAP2 3

`define RST_COMPARE 16'h8000
`define RST_COUNT 16'hFFFC
`define TRIG_CAPTURE 16'hFFFD

`define TICK_DIV2 2'b00
`define TICK_DIV4 2'b01
`define TICK_DIV8 2'b10
`define TICK_EXT 2'b11

`endif

// ---- hdl/timer_output_compare_one_pulse.v ----
// output compare and one-pulse section of a 16-bit timer with an apb register port
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "timer_cmp_map.vh"

// What this block does
// - compare both registers to counter each tick
// - compare registers software only, reset 8000h
// - match sets its compare flag outside pwm mode, flag one also not in one-pulse
// - enabled match drives level; pin reset low
// - compare irq needs enable and mask clear
// - status read then low access clears flag
// - high byte write inhibits until low write
// - disabled pin acts as plain port
// - div2 match at value, slower at value+1
// - force copies level, no flag, no irq
// - force ignored in one-pulse or pwm
// - control two bit selects one-pulse mode
// - trigger reloads counter, capture FFFDh, pulse level
// - compare one match ends pulse with level
// - trigger capture flag raises capture interrupt
// - one-pulse never sets compare flag one
// - pwm wins over one-pulse
// - capture one idle in one-pulse, two works
// - compare two drives no waveform in one-pulse
// - pulse spans compare one plus four ticks at div2, plus five slower
// - equal levels give constant pin level
// - counter reset and reload value FFFCh
// - tick select div2, div4, div8, external
module timer_output_compare_one_pulse #(
  parameter CW = 16
) (
  // clock and reset
  input wire SYS_CLK,
  input wire SYS_RST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // timer pins
  input wire CAP_IN1,
  input wire CAP_IN2,
  input wire EXT_TICK,
  input wire PORT_DATA1,
  input wire PORT_DATA2,
  output reg CMP_PIN1,
  output reg CMP_PIN2,
  // interrupt
  input wire CPU_IRQ_MASK,
  output reg TIMER_IRQ
);

  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [CW-1:0] cmp1_q;
  reg [CW-1:0] cmp2_q;
  reg [CW-1:0] cap1_q;
  reg [CW-1:0] cap2_q;
  reg [CW-1:0] count_q;
  reg [2:0] div_q;
  reg ext_prev_q;
  reg cap1_prev_q;
  reg cap2_prev_q;
  reg [1:0] inhibit_q;
  reg [1:0] matched_q;
  reg [3:0] flag_q;
  reg [3:0] arm_q;
  reg lat1_q;
  reg lat2_q;

  wire wr_done = PSEL & PENABLE & PREADY & PWRITE;
  wire rd_done = PSEL & PENABLE & PREADY & ~PWRITE;
  wire acc_done = PSEL & PENABLE & PREADY;
  wire [7:0] wb = PWDATA[7:0];

  // mode decode
  wire pwm_mode = ctrl2_q[`C2_PWM];
  wire opm_mode = ctrl2_q[`C2_SINGLE_PULSE] & ~pwm_mode;
  wire [1:0] tick_sel = {ctrl2_q[`C2_TICK_HI], ctrl2_q[`C2_TICK_LO]};

  // tick generation
  wire ext_edge = ctrl2_q[`C2_EXT_EDGE] ? (EXT_TICK & ~ext_prev_q) : (~EXT_TICK & ext_prev_q);
  reg tick;
  always @* begin
    case (tick_sel)
      `TICK_DIV2: tick = (div_q[0] == 1'b1);
      `TICK_DIV4: tick = (div_q[1:0] == 2'b11);
      `TICK_DIV8: tick = (div_q == 3'b111);
      default: tick = ext_edge;
    endcase
  end

  // edge detect on capture inputs
  wire cap1_edge = ctrl1_q[`C1_TRIG_EDGE] ? (CAP_IN1 & ~cap1_prev_q) : (~CAP_IN1 & cap1_prev_q);
  wire cap2_edge = ctrl2_q[`C2_CAP2_EDGE] ? (CAP_IN2 & ~cap2_prev_q) : (~CAP_IN2 & cap2_prev_q);
  wire trigger = opm_mode & cap1_edge;

  // match detect: at value for div2, at value plus one otherwise
  wire div2 = (tick_sel == `TICK_DIV2);
  wire [CW-1:0] tgt1 = div2 ? cmp1_q : cmp1_q + {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] tgt2 = div2 ? cmp2_q : cmp2_q + {{(CW-1){1'b0}}, 1'b1};
  wire eq1 = (count_q == tgt1);
  wire eq2 = (count_q == tgt2);
  wire hit1 = eq1 & ~matched_q[0] & ~inhibit_q[0];
  wire hit2 = eq2 & ~matched_q[1] & ~inhibit_q[1];

  // access decode
  wire rd_status = rd_done & (PADDR == `OFS_STATUS);
  wire lo1_acc = acc_done & (PADDR == `OFS_CMP1_LO);
  wire lo2_acc = acc_done & (PADDR == `OFS_CMP2_LO);
  wire cap1_lo_acc = acc_done & (PADDR == `OFS_CAP1_LO);
  wire cap2_lo_acc = acc_done & (PADDR == `OFS_CAP2_LO);
  wire wr_ctrl1 = wr_done & (PADDR == `OFS_CTRL_ONE);
  wire force_ok = ~opm_mode & ~pwm_mode;

  // flag set terms
  wire [3:0] flag_set;
  assign flag_set[`ST_CMP1] = hit1 & ~pwm_mode & ~opm_mode;
  assign flag_set[`ST_CMP2] = hit2 & ~pwm_mode;
  assign flag_set[`ST_CAP1] = trigger | (pwm_mode & hit2) | (~opm_mode & ~pwm_mode & cap1_edge);
  assign flag_set[`ST_CAP2] = cap2_edge;
  wire [3:0] flag_clr = arm_q & {cap2_lo_acc, cap1_lo_acc, lo2_acc, lo1_acc};

  // register read mux
  reg [31:0] rd_data;
  reg rd_err;
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (PADDR == `OFS_CTRL_ONE) begin
      rd_data[7:0] = {ctrl1_q[7:5], 2'b00, ctrl1_q[2:0]};
    end else if (PADDR == `OFS_CTRL_TWO) begin
      rd_data[7:0] = ctrl2_q;
    end else if (PADDR == `OFS_STATUS) begin
      rd_data[3:0] = flag_q;
    end else if (PADDR == `OFS_CMP1_HI) begin
      rd_data[7:0] = cmp1_q[15:8];
    end else if (PADDR == `OFS_CMP1_LO) begin
      rd_data[7:0] = cmp1_q[7:0];
    end else if (PADDR == `OFS_CMP2_HI) begin
      rd_data[7:0] = cmp2_q[15:8];
    end else if (PADDR == `OFS_CMP2_LO) begin
      rd_data[7:0] = cmp2_q[7:0];
    end else if (PADDR == `OFS_CAP1_HI) begin
      rd_data[7:0] = cap1_q[15:8];
    end else if (PADDR == `OFS_CAP1_LO) begin
      rd_data[7:0] = cap1_q[7:0];
    end else if (PADDR == `OFS_CAP2_HI) begin
      rd_data[7:0] = cap2_q[15:8];
    end else if (PADDR == `OFS_CAP2_LO) begin
      rd_data[7:0] = cap2_q[7:0];
    end else if (PADDR == `OFS_COUNT_HI) begin
      rd_data[7:0] = count_q[15:8];
    end else if (PADDR == `OFS_COUNT_LO) begin
      rd_data[7:0] = count_q[7:0];
    end else begin
      rd_err = 1'b1;
    end
  end

  // apb handshake: one wait state, answer registered
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL & PENABLE & ~PREADY) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_data;
      // unmapped writes are dropped quietly, only reads report an error
      PSLVERR <= ~PWRITE & rd_err;
    end else begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // control registers; force bits are strobes and never stored
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl1_q <= 8'h00;
      ctrl2_q <= 8'h00;
    end else begin
      if (wr_ctrl1) begin
        ctrl1_q <= {wb[7:5], 2'b00, wb[2:0]};
      end
      if (wr_done & (PADDR == `OFS_CTRL_TWO)) begin
        ctrl2_q <= wb;
      end
    end
  end

  // compare registers and high byte inhibit
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cmp1_q <= `RST_COMPARE;
      cmp2_q <= `RST_COMPARE;
      inhibit_q <= 2'b00;
    end else if (wr_done) begin
      if (PADDR == `OFS_CMP1_HI) begin
        cmp1_q[15:8] <= wb;
        inhibit_q[0] <= 1'b1;
      end else if (PADDR == `OFS_CMP1_LO) begin
        cmp1_q[7:0] <= wb;
        inhibit_q[0] <= 1'b0;
      end else if (PADDR == `OFS_CMP2_HI) begin
        cmp2_q[15:8] <= wb;
        inhibit_q[1] <= 1'b1;
      end else if (PADDR == `OFS_CMP2_LO) begin
        cmp2_q[7:0] <= wb;
        inhibit_q[1] <= 1'b0;
      end
    end
  end

  // prescaler and free-running counter
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      div_q <= 3'b000;
      ext_prev_q <= 1'b0;
      count_q <= `RST_COUNT;
      matched_q <= 2'b00;
    end else begin
      div_q <= div_q + 3'b001;
      ext_prev_q <= EXT_TICK;
      if (trigger | (pwm_mode & hit2) | (wr_done & (PADDR == `OFS_COUNT_LO))) begin
        count_q <= `RST_COUNT;
        matched_q <= 2'b00;
      end else if (tick) begin
        count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
        matched_q <= 2'b00;
      end else begin
        matched_q <= matched_q | {eq2, eq1};
      end
    end
  end

  // status flags, set wins over clear
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      flag_q <= 4'h0;
      arm_q <= 4'h0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
      if (rd_status) begin
        arm_q <= flag_q;
      end else begin
        arm_q <= arm_q & ~{cap2_lo_acc, cap1_lo_acc, lo2_acc, lo1_acc};
      end
    end
  end

  // capture registers
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
      cap1_prev_q <= 1'b0;
      cap2_prev_q <= 1'b0;
    end else begin
      cap1_prev_q <= CAP_IN1;
      cap2_prev_q <= CAP_IN2;
      if (trigger) begin
        cap1_q <= `TRIG_CAPTURE;
      end else if (~opm_mode & ~pwm_mode & cap1_edge) begin
        cap1_q <= count_q;
      end
      if (cap2_edge) begin
        cap2_q <= count_q;
      end
    end
  end

  // compare pin latches
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      lat1_q <= 1'b0;
      lat2_q <= 1'b0;
    end else if (opm_mode) begin
      if (trigger) begin
        lat1_q <= ctrl1_q[`C1_LEVEL_DURING];
      end else if (hit1) begin
        lat1_q <= ctrl1_q[`C1_LEVEL_AFTER];
      end
    end else if (pwm_mode) begin
      if (hit2) begin
        lat1_q <= ctrl1_q[`C1_LEVEL_DURING];
      end else if (hit1) begin
        lat1_q <= ctrl1_q[`C1_LEVEL_AFTER];
      end
    end else begin
      if (hit1 | (wr_ctrl1 & wb[`C1_FORCE1] & force_ok)) begin
        lat1_q <= ctrl1_q[`C1_LEVEL_AFTER];
      end
      if (hit2 | (wr_ctrl1 & wb[`C1_FORCE2] & force_ok)) begin
        lat2_q <= ctrl1_q[`C1_LEVEL_DURING];
      end
    end
  end

  // pins and interrupt
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CMP_PIN1 <= 1'b0;
      CMP_PIN2 <= 1'b0;
      TIMER_IRQ <= 1'b0;
    end else begin
      CMP_PIN1 <= ctrl2_q[`C2_PIN_EN1] ? lat1_q : PORT_DATA1;
      CMP_PIN2 <= ctrl2_q[`C2_PIN_EN2] ? lat2_q : PORT_DATA2;
      TIMER_IRQ <= ~CPU_IRQ_MASK &
        ((ctrl1_q[`C1_CMP_IRQ_EN] & (flag_q[`ST_CMP1] | flag_q[`ST_CMP2])) |
         (ctrl1_q[`C1_CAP_IRQ_EN] & (flag_q[`ST_CAP1] | flag_q[`ST_CAP2])));
    end
  end

endmodule

// ---- tb/pulse_load.sv ----
// far side: fires the trigger input and times the pulse on compare pin one
`timescale 1ns/1ps
module pulse_load (
  input wire clk,
  input wire fire,
  input wire pin,
  output reg trig,
  output reg [15:0] width_q
);
  initial trig = 1'b0;
  initial width_q = 16'h0000;
  always @(posedge clk) begin
    if (fire)
      trig <= 1'b1;
    if (pin && trig)
      width_q <= width_q + 16'h0001;
  end
endmodule

// ---- tb/timer_cmp_chk.sv ----
// port checker for the compare timer block
`timescale 1ns/1ps
`include "timer_cmp_map.vh"
module timer_cmp_chk (
  // clock and reset
  input wire SYS_CLK,
  input wire SYS_RST,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  // pins
  input wire PORT_DATA2,
  input wire CMP_PIN1,
  input wire CMP_PIN2,
  input wire CPU_IRQ_MASK,
  input wire TIMER_IRQ
);
  reg [7:0] c1_q;
  reg [7:0] c2_q;
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
  // shadow of the two control registers
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
    end else if (wr_done && PADDR == `OFS_CTRL_ONE) begin
      c1_q <= PWDATA[7:0];
    end else if (wr_done && PADDR == `OFS_CTRL_TWO) begin
      c2_q <= PWDATA[7:0];
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_pin_reset_low: assert property (disable iff (1'b0)
    SYS_RST |=> !CMP_PIN1 && !CMP_PIN2) else $error("pins not low after reset");
  a_ready_after_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready missing");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("ready too long");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data not zero");
  a_rdata_byte: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_err: assert property (PREADY |-> PSLVERR == (!PWRITE && PADDR > `OFS_COUNT_LO))
    else $error("slave error wrong");
  a_irq_cause: assert property (TIMER_IRQ |->
    !$past(CPU_IRQ_MASK) && $past(c1_q[6] || c1_q[7])) else $error("irq without cause");
  a_port_mode: assert property ($past(c2_q[1]) == 1'b0 && $stable(PORT_DATA2) |->
    CMP_PIN2 == PORT_DATA2) else $error("pin2 not port data");
  c_err: cover property (PREADY && PSLVERR);
  c_irq: cover property ($rose(TIMER_IRQ));
  c_pulse: cover property ($rose(CMP_PIN1));
endmodule

// ---- tb/timer_output_compare_one_pulse_bench.sv ----
// self-checking bench for the compare timer block
`timescale 1ns/1ps
`include "timer_cmp_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module timer_output_compare_one_pulse_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg pen = 1'b0;
  reg pwr = 1'b0;
  reg [11:0] pa = 12'h000;
  reg [31:0] pwd = 32'h0;
  reg pd1 = 1'b0;
  reg pd2 = 1'b0;
  reg mask = 1'b0;
  reg fire = 1'b0;
  reg cap2 = 1'b0;
  wire [31:0] prd;
  wire prdy, perr, cap1, pin1, pin2, irq;
  wire [15:0] width;
  integer miscompares = 0;
  integer comparisons = 0;
  integer n;
  reg [31:0] rd;
  reg err;
  always #5 clk = ~clk;
  timer_output_compare_one_pulse dut_u (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .CAP_IN1(cap1), .CAP_IN2(cap2), .EXT_TICK(1'b0), .PORT_DATA1(pd1),
    .PORT_DATA2(pd2), .CMP_PIN1(pin1), .CMP_PIN2(pin2), .CPU_IRQ_MASK(mask), .TIMER_IRQ(irq));
  pulse_load load_u (.clk(clk), .fire(fire), .pin(pin1), .trig(cap1), .width_q(width));
  task apb(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (prdy !== 1'b1 && n < 20);
      if (n >= 20)
        miscompares++;
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task wait_pin1(input v);
    begin
      n = 0;
      while (pin1 !== v && n < 300) begin
        @(posedge clk);
        n++;
      end
    end
  endtask
  task t_reset;
    begin
      apb(0, `OFS_CMP1_HI, 0);
      `CHK("cmp1 hi", 32'h80, rd)
      apb(1, `OFS_CMP2_LO, 8'hC3);
      apb(0, `OFS_CMP2_LO, 0);
      `CHK("cmp2 lo", 32'hC3, rd)
      apb(0, 12'h100, 0);
      `CHK("unmapped", 1'b1, err)
      apb(1, 12'h100, 8'h00);
      `CHK("unmapped wr", 1'b0, err)
      `CHK("pins", 2'b00, {pin1, pin2})
    end
  endtask
  task t_match;
    begin
      mask <= 1'b1;
      apb(1, `OFS_CTRL_TWO, 8'h03);
      apb(1, `OFS_CTRL_ONE, 8'h41);
      apb(1, `OFS_CMP1_HI, 8'h00);
      apb(1, `OFS_CMP1_LO, 8'h10);
      apb(1, `OFS_COUNT_LO, 8'h00);
      wait_pin1(1'b1);
      `CHK("pin1 level", 1'b1, pin1)
      repeat (3) @(posedge clk);
      `CHK("irq masked", 1'b0, irq)
      mask <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      apb(0, `OFS_STATUS, 0);
      `CHK("flag1", 32'h1, rd)
      apb(0, `OFS_CMP1_LO, 0);
      apb(0, `OFS_STATUS, 0);
      `CHK("flag1 clear", 32'h0, rd)
    end
  endtask
  task t_inhibit;
    begin
      apb(1, `OFS_CMP1_HI, 8'h00);
      apb(1, `OFS_COUNT_LO, 8'h00);
      repeat (60) @(posedge clk);
      apb(0, `OFS_STATUS, 0);
      `CHK("inhibited", 32'h0, rd)
      apb(1, `OFS_CMP1_LO, 8'h10);
      apb(1, `OFS_COUNT_LO, 8'h00);
      repeat (60) @(posedge clk);
      apb(0, `OFS_STATUS, 0);
      `CHK("re-enabled", 32'h1, rd)
      apb(0, `OFS_CMP1_LO, 0);
    end
  endtask
  task t_force;
    begin
      apb(1, `OFS_CTRL_ONE, 8'h04);
      apb(1, `OFS_CTRL_ONE, 8'h14);
      repeat (3) @(posedge clk);
      `CHK("forced pin2", 1'b1, pin2)
      apb(1, `OFS_CTRL_ONE, 8'h08);
      repeat (3) @(posedge clk);
      `CHK("forced pin1", 1'b0, pin1)
      apb(0, `OFS_STATUS, 0);
      `CHK("no flag", 32'h0, rd)
      `CHK("no irq", 1'b0, irq)
    end
  endtask
  task t_port;
    begin
      apb(1, `OFS_CTRL_TWO, 8'h01);
      repeat (3) @(posedge clk);
      `CHK("port low", 1'b0, pin2)
      pd2 <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("port high", 1'b1, pin2)
    end
  endtask
  task t_pulse;
    begin
      apb(1, `OFS_CMP1_HI, 8'h00);
      apb(1, `OFS_CMP1_LO, 8'h0A);
      apb(1, `OFS_CTRL_ONE, 8'h86);
      apb(1, `OFS_CTRL_TWO, 8'h05);
      fire <= 1'b1;
      wait_pin1(1'b1);
      wait_pin1(1'b0);
      `CHK("pulse len", 1'b1, width >= 16'd28 && width <= 16'd32)
      apb(0, `OFS_STATUS, 0);
      `CHK("opm flags", 32'h4, rd)
      `CHK("cap irq", 1'b1, irq)
      apb(0, `OFS_CAP1_HI, 0);
      `CHK("cap1 hi", 32'hFF, rd)
      apb(0, `OFS_CAP1_LO, 0);
      `CHK("cap1 lo", 32'hFD, rd)
      cap2 <= 1'b1;
      repeat (2) @(posedge clk);
      cap2 <= 1'b0;
      repeat (3) @(posedge clk);
      apb(0, `OFS_STATUS, 0);
      `CHK("cap2 in opm", 32'h8, rd)
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_match;
    t_inhibit;
    t_force;
    t_port;
    t_pulse;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule
bind timer_output_compare_one_pulse timer_cmp_chk chk_u (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_DATA2(PORT_DATA2),
  .CMP_PIN1(CMP_PIN1), .CMP_PIN2(CMP_PIN2), .CPU_IRQ_MASK(CPU_IRQ_MASK), .TIMER_IRQ(TIMER_IRQ));
